// >>> smsw_defines.svh
/*
  timing figures, bus codes and derived cycle counts for the start-up
  mode select and wake-up sequencer; assumes a 200 MHz core clock
*/
`ifndef SMSW_DEFINES_SVH
`define SMSW_DEFINES_SVH

// core clock rate
`define SMSW_CLK_MHZ 200.0

// times in their own units
`define SMSW_T_INI_MS 10.2
`define SMSW_T_NM_US 110.0
`define SMSW_T_RESUME_US 750.0
`define SMSW_T_WIN_TYP_S 2.8
`define SMSW_T_LOW_FREQ_RX_MS 5.3
`define SMSW_T_INTERVAL_MS 6.0
`define SMSW_T_PIN_MS 6.0
`define SMSW_T_RUN_US 550.0
`define SMSW_T_PD_HOLD_MS 4.0
`define SMSW_T_BOOT_US 500.0

// all times round down to whole cycles
`define SMSW_CYC_INI int'($floor(`SMSW_T_INI_MS * 1000.0 * `SMSW_CLK_MHZ))
`define SMSW_CYC_NM int'($floor(`SMSW_T_NM_US * `SMSW_CLK_MHZ))
`define SMSW_CYC_RESUME int'($floor(`SMSW_T_RESUME_US * `SMSW_CLK_MHZ))
`define SMSW_CYC_WIN int'($floor(`SMSW_T_WIN_TYP_S * 1000000.0 * `SMSW_CLK_MHZ))
`define SMSW_CYC_LOW_FREQ_RX int'($floor(`SMSW_T_LOW_FREQ_RX_MS * 1000.0 * `SMSW_CLK_MHZ))
`define SMSW_CYC_INTERVAL int'($floor(`SMSW_T_INTERVAL_MS * 1000.0 * `SMSW_CLK_MHZ))
`define SMSW_CYC_PIN int'($floor(`SMSW_T_PIN_MS * 1000.0 * `SMSW_CLK_MHZ))
`define SMSW_CYC_RUN int'($floor(`SMSW_T_RUN_US * `SMSW_CLK_MHZ))
`define SMSW_CYC_PD_HOLD int'($floor(`SMSW_T_PD_HOLD_MS * 1000.0 * `SMSW_CLK_MHZ))
`define SMSW_CYC_BOOT int'($floor(`SMSW_T_BOOT_US * `SMSW_CLK_MHZ))

// serial command codes
`define SMSW_DEV_ADDR 8'h6c
`define SMSW_CODE_NORMAL 16'h9876
`define SMSW_CODE_PROGRAM 16'h1f5a
`define SMSW_CODE_DEBUG 16'hfedc
`define SMSW_SEL_BYTES 3'h3

`endif

// >>> smsw_pkg.sv
/*
  types of the start-up mode select and wake-up sequencer;
  constants live in smsw_defines.svh
*/
package smsw_pkg;

  typedef enum logic [1:0] {
    SMSW_MODE_NORMAL = 2'b00,
    SMSW_MODE_PROGRAM = 2'b01,
    SMSW_MODE_DEBUG = 2'b10
  } smsw_mode_t;

  typedef enum logic [2:0] {
    SMSW_ST_SELECT = 3'b000,
    SMSW_ST_RUN = 3'b001,
    SMSW_ST_IDLE = 3'b010,
    SMSW_ST_DEEP = 3'b011,
    SMSW_ST_PD = 3'b100,
    SMSW_ST_PD_HOLD = 3'b101,
    SMSW_ST_BOOT = 3'b110,
    SMSW_ST_HOST = 3'b111
  } smsw_state_t;

endpackage

// >>> smsw_top.sv
/*
  start-up mode select over the two-wire port, power state sequencing
  and shared pin routing. assumes: reset_n_in is the power-on reset and
  is released once the supply is above supply_threshold; wake sources
  and pins are asynchronous; enter_* requests come from core logic.
*/
`timescale 1ns/1ps
`include "smsw_defines.svh"

module smsw_top import smsw_pkg::*; #(
  parameter int WIN_CYCLES = `SMSW_CYC_WIN,
  parameter int PD_HOLD_CYCLES = `SMSW_CYC_PD_HOLD,
  parameter int BOOT_CYCLES = `SMSW_CYC_BOOT,
  parameter int INI_CYCLES = `SMSW_CYC_INI
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic wake_pin_uart_rx_in,
  output logic wake_pin_uart_rx_out,
  output logic wake_pin_uart_rx_oe_out,
  input wire logic gpio_uart_tx_in,
  output logic gpio_uart_tx_out,
  output logic gpio_uart_tx_oe_out,
  input wire logic [3:0] gpio_dout_in,
  input wire logic [3:0] gpio_oe_in,
  output logic [3:0] gpio_din_out,
  input wire logic uart_sel_in,
  input wire logic uart_tx_in,
  output logic uart_rx_out,
  input wire logic wake_pin_en_in,
  input wire logic low_frequency_receiver_in,
  input wire logic interval_timer_in,
  input wire logic resume_in,
  input wire logic enter_idle_in,
  input wire logic enter_deep_idle_in,
  input wire logic enter_powerdown_in,
  output logic handler_ready_out,
  output logic window_open_out,
  output logic mode_valid_out,
  output smsw_mode_t mode_out,
  output logic app_start_out,
  output logic restart_vector_out,
  output logic cpu_run_out,
  output logic power_down_out,
  output logic [7:0] host_byte_out,
  output logic host_byte_valid_out
);

  // two-flop synchronisers, third stage for edges
  logic [6:0] sync1_q, sync2_q, sync3_q;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sync1_q <= 7'h03; // two-wire lines idle high, no false edge
      sync2_q <= 7'h03;
      sync3_q <= 7'h03;
    end else begin
      sync1_q <= {resume_in, interval_timer_in, low_frequency_receiver_in, gpio_uart_tx_in,
                  wake_pin_uart_rx_in, sda_in, scl_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, pin_change, wake_ev;
  assign scl_rise = sync2_q[0] & ~sync3_q[0];
  assign scl_fall = ~sync2_q[0] & sync3_q[0];
  assign bus_start = sync2_q[0] & sync3_q[0] & ~sync2_q[1] & sync3_q[1];
  assign bus_stop = sync2_q[0] & sync3_q[0] & sync2_q[1] & ~sync3_q[1];
  assign pin_change = wake_pin_en_in & (sync2_q[2] ^ sync3_q[2]);
  assign wake_ev = sync2_q[4] | sync2_q[5] | pin_change;

  // mode decision from a two-byte code
  function automatic smsw_mode_t smsw_decode(input logic [15:0] code);
    case (code)
      `SMSW_CODE_PROGRAM: smsw_decode = SMSW_MODE_PROGRAM;
      `SMSW_CODE_DEBUG: smsw_decode = SMSW_MODE_DEBUG;
      default: smsw_decode = SMSW_MODE_NORMAL;
    endcase
  endfunction

  // two-wire receiver and mode selection window
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, hb_q, hb_d;
  logic [2:0] byte_q, byte_d;
  logic busy_q, busy_d, sel_q, sel_d, ack_q, ack_d, hv_q, hv_d;
  logic [15:0] code_q, code_d;
  logic [29:0] win_q, win_d;
  logic decided_q, decided_d, rdy_q, rdy_d;
  smsw_mode_t mode_q, mode_d;
  logic host_mode, decide_cmd, decide_win;

  assign host_mode = decided_q & (mode_q != SMSW_MODE_NORMAL);
  assign decide_cmd = bus_stop & busy_q & sel_q & !decided_q
                      & (byte_q == `SMSW_SEL_BYTES);
  assign decide_win = !decided_q & (win_q == 30'(WIN_CYCLES - 1));

  always_comb begin
    bit_d = bit_q;
    sh_d = sh_q;
    byte_d = byte_q;
    busy_d = busy_q;
    sel_d = sel_q;
    ack_d = ack_q;
    code_d = code_q;
    win_d = win_q;
    decided_d = decided_q;
    mode_d = mode_q;
    hb_d = hb_q;
    hv_d = 1'b0;
    rdy_d = 1'b1; // handler live one cycle after reset release
    if (!decided_q) begin
      win_d = win_q + 30'h0000_0001;
    end
    if (bus_start) begin
      bit_d = 4'h0;
      byte_d = 3'h0;
      busy_d = 1'b1;
      sel_d = 1'b0;
      ack_d = 1'b0;
    end else if (bus_stop) begin
      busy_d = 1'b0;
      ack_d = 1'b0;
    end else if (busy_q && scl_rise) begin
      if (bit_q == 4'h8) begin
        bit_d = 4'h0;
        if (byte_q != 3'h4) begin
          byte_d = byte_q + 3'h1;
        end
      end else begin
        sh_d = {sh_q[6:0], sync2_q[1]};
        bit_d = bit_q + 4'h1;
      end
    end else if (busy_q && scl_fall) begin
      if (bit_q == 4'h8) begin
        if (byte_q == 3'h0) begin
          // only answer while a selection is pending or the master owns us
          sel_d = (sh_q == `SMSW_DEV_ADDR) & (!decided_q | host_mode);
          ack_d = (sh_q == `SMSW_DEV_ADDR) & (!decided_q | host_mode);
        end else if (sel_q) begin
          ack_d = 1'b1;
          if (host_mode) begin
            hb_d = sh_q;
            hv_d = 1'b1;
          end else if (byte_q == 3'h1) begin
            code_d[15:8] = sh_q;
          end else if (byte_q == 3'h2) begin
            code_d[7:0] = sh_q;
          end
        end
      end else if (bit_q == 4'h0) begin
        ack_d = 1'b0;
      end
    end
    if (decide_cmd) begin
      decided_d = 1'b1;
      mode_d = smsw_decode(code_q);
    end else if (decide_win) begin
      decided_d = 1'b1;
      mode_d = SMSW_MODE_NORMAL;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      byte_q <= 3'h0;
      busy_q <= 1'b0;
      sel_q <= 1'b0;
      ack_q <= 1'b0;
      code_q <= 16'h0000;
      win_q <= 30'h0000_0000;
      decided_q <= 1'b0;
      mode_q <= SMSW_MODE_NORMAL;
      hb_q <= 8'h00;
      hv_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      sh_q <= sh_d;
      byte_q <= byte_d;
      busy_q <= busy_d;
      sel_q <= sel_d;
      ack_q <= ack_d;
      code_q <= code_d;
      win_q <= win_d;
      decided_q <= decided_d;
      mode_q <= mode_d;
      hb_q <= hb_d;
      hv_q <= hv_d;
      rdy_q <= rdy_d;
    end
  end

  // power state sequencing
  smsw_state_t st_q, st_d;
  logic [19:0] cnt_q, cnt_d;
  logic start_q, start_d, rv_q, rv_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 20'h0_0001;
    start_d = 1'b0;
    rv_d = rv_q;
    case (st_q)
      SMSW_ST_SELECT: begin
        if (decided_d && mode_d == SMSW_MODE_NORMAL) begin
          st_d = SMSW_ST_RUN;
          start_d = 1'b1;
          rv_d = 1'b1;
        end else if (decided_d) begin
          st_d = SMSW_ST_HOST;
        end
      end
      SMSW_ST_RUN: begin
        if (enter_powerdown_in) begin
          st_d = SMSW_ST_PD;
        end else if (enter_deep_idle_in) begin
          st_d = SMSW_ST_DEEP;
        end else if (enter_idle_in) begin
          st_d = SMSW_ST_IDLE;
        end
      end
      SMSW_ST_IDLE: begin
        if (wake_ev || sync2_q[6]) begin
          st_d = SMSW_ST_RUN;
          start_d = 1'b1;
          rv_d = 1'b0;
        end
      end
      SMSW_ST_DEEP: begin
        if (wake_ev || sync2_q[6]) begin
          st_d = SMSW_ST_BOOT;
          cnt_d = 20'h0_0000;
        end
      end
      SMSW_ST_PD: begin
        if (wake_ev) begin
          st_d = SMSW_ST_PD_HOLD; // most of the wait stays powered down
          cnt_d = 20'h0_0000;
        end
      end
      SMSW_ST_PD_HOLD: begin
        if (cnt_q == 20'(PD_HOLD_CYCLES - 1)) begin
          st_d = SMSW_ST_BOOT;
          cnt_d = 20'h0_0000;
        end
      end
      SMSW_ST_BOOT: begin
        if (cnt_q == 20'(BOOT_CYCLES - 1)) begin
          st_d = SMSW_ST_RUN;
          start_d = 1'b1;
          rv_d = 1'b1;
        end
      end
      SMSW_ST_HOST: st_d = SMSW_ST_HOST;
      default: st_d = SMSW_ST_SELECT;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_q <= SMSW_ST_SELECT;
      cnt_q <= 20'h0_0000;
      start_q <= 1'b0;
      rv_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      start_q <= start_d;
      rv_q <= rv_d;
    end
  end

  // pin routing, registered
  logic [7:0] pin_q, pin_d;
  logic [4:0] din_q, din_d;
  logic two_wire;
  assign two_wire = !decided_q | host_mode;

  always_comb begin
    pin_d[0] = gpio_dout_in[0];
    pin_d[1] = two_wire ? 1'b0 : gpio_oe_in[0];
    pin_d[2] = two_wire ? 1'b0 : gpio_dout_in[1];
    pin_d[3] = two_wire ? ack_q : gpio_oe_in[1];
    pin_d[4] = gpio_dout_in[2];
    pin_d[5] = uart_sel_in ? 1'b0 : gpio_oe_in[2];
    pin_d[6] = uart_sel_in ? uart_tx_in : gpio_dout_in[3];
    pin_d[7] = uart_sel_in | gpio_oe_in[3];
    din_d = {sync2_q[2], sync2_q[3:0]};
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pin_q <= 8'h00;
      din_q <= 5'h00;
    end else begin
      pin_q <= pin_d;
      din_q <= din_d;
    end
  end

  assign scl_out = pin_q[0];
  assign scl_oe_out = pin_q[1];
  assign sda_out = pin_q[2];
  assign sda_oe_out = pin_q[3];
  assign wake_pin_uart_rx_out = pin_q[4];
  assign wake_pin_uart_rx_oe_out = pin_q[5];
  assign gpio_uart_tx_out = pin_q[6];
  assign gpio_uart_tx_oe_out = pin_q[7];
  assign gpio_din_out = din_q[3:0];
  assign uart_rx_out = din_q[4];
  assign handler_ready_out = rdy_q;
  assign window_open_out = !decided_q;
  assign mode_valid_out = decided_q;
  assign mode_out = mode_q;
  assign app_start_out = start_q;
  assign restart_vector_out = rv_q;
  assign cpu_run_out = (st_q == SMSW_ST_RUN);
  assign power_down_out = (st_q == SMSW_ST_PD) | (st_q == SMSW_ST_PD_HOLD);
  assign host_byte_out = hb_q;
  assign host_byte_valid_out = hv_q;

  // helper: cycles since reset release and since a power-down or deep idle wake
  logic [31:0] age_q, wk_q;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      age_q <= 32'h0000_0000;
      wk_q <= 32'h0000_0000;
    end else begin
      age_q <= (age_q == 32'hffff_ffff) ? age_q : age_q + 32'h0000_0001;
      wk_q <= (st_q == SMSW_ST_PD_HOLD || st_q == SMSW_ST_BOOT) ? wk_q + 32'h0000_0001
              : 32'h0000_0000;
    end
  end

  sequence s_normal_cmd;
    decide_cmd && smsw_decode(code_q) == SMSW_MODE_NORMAL;
  endsequence
  sequence s_app_fresh;
    app_start_out && restart_vector_out && cpu_run_out;
  endsequence

  property p_handler;
    @(posedge clk_in) disable iff (!reset_n_in)
      (age_q >= 32'(INI_CYCLES)) |-> handler_ready_out;
  endproperty
  a_handler: assert property (p_handler) else $error("handler not running in time");

  property p_normal;
    @(posedge clk_in) disable iff (!reset_n_in)
      s_normal_cmd |=> s_app_fresh;
  endproperty
  a_normal: assert property (p_normal) else $error("normal mode start late");

  property p_window;
    @(posedge clk_in) disable iff (!reset_n_in)
      decide_win |=> mode_valid_out && mode_out == SMSW_MODE_NORMAL && app_start_out;
  endproperty
  a_window: assert property (p_window) else $error("window close not normal");

  property p_program;
    @(posedge clk_in) disable iff (!reset_n_in)
      decide_cmd && code_q == `SMSW_CODE_PROGRAM |=> mode_out == SMSW_MODE_PROGRAM
        ##1 (!cpu_run_out && !app_start_out) [*2];
  endproperty
  a_program: assert property (p_program) else $error("program mode not entered");

  property p_debug;
    @(posedge clk_in) disable iff (!reset_n_in)
      decide_cmd && code_q == `SMSW_CODE_DEBUG |=> mode_out == SMSW_MODE_DEBUG;
  endproperty
  a_debug: assert property (p_debug) else $error("debug mode not entered");

  property p_locked;
    @(posedge clk_in) disable iff (!reset_n_in)
      mode_valid_out |=> mode_valid_out && $stable(mode_out);
  endproperty
  a_locked: assert property (p_locked) else $error("mode changed after lock");

  property p_pd_wake;
    @(posedge clk_in) disable iff (!reset_n_in)
      wk_q <= 32'(`SMSW_CYC_LOW_FREQ_RX)
        && (st_q != SMSW_ST_BOOT || cnt_q < 20'(`SMSW_CYC_RUN));
  endproperty
  a_pd_wake: assert property (p_pd_wake) else $error("wake latency exceeded");

  property p_idle;
    @(posedge clk_in) disable iff (!reset_n_in)
      st_q == SMSW_ST_IDLE && (wake_ev || sync2_q[6]) |=> app_start_out && !restart_vector_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle resume not continuing");

  property p_deep;
    @(posedge clk_in) disable iff (!reset_n_in)
      st_q == SMSW_ST_BOOT |-> cnt_q < 20'(`SMSW_CYC_RESUME);
  endproperty
  a_deep: assert property (p_deep) else $error("deep idle resume too slow");

  // every boot ends in a fresh start from the reset vector
  property p_boot_vec;
    @(posedge clk_in) disable iff (!reset_n_in)
      st_q == SMSW_ST_BOOT && st_d == SMSW_ST_RUN |=> s_app_fresh;
  endproperty
  a_boot_vec: assert property (p_boot_vec) else $error("boot not from reset vector");

  property p_tx_pin;
    @(posedge clk_in) disable iff (!reset_n_in)
      uart_sel_in |=> gpio_uart_tx_oe_out && gpio_uart_tx_out == $past(uart_tx_in);
  endproperty
  a_tx_pin: assert property (p_tx_pin) else $error("transmit pin not routed");

endmodule // smsw_top

// >>> smsw_top_tb.sv
/*
  self-checking bench for the mode select and wake-up sequencer.
  assumes smsw_twi_master as bus partner and pull-ups on both wires.
*/
`timescale 1ns/1ps
`include "smsw_defines.svh"
module smsw_top_tb import smsw_pkg::*; ;
  localparam int WIN = 3000;
  localparam int PDH = 50;
  localparam int BOOT = 20;
  localparam int INI = 10;
  logic clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic m_scl, m_sda, scl_in, sda_in, scl_out, scl_oe_out, sda_out, sda_oe_out;
  logic wake_pin_uart_rx_in = 1'h0, wake_pin_uart_rx_out, wake_pin_uart_rx_oe_out;
  logic gpio_uart_tx_in = 1'h0, gpio_uart_tx_out, gpio_uart_tx_oe_out;
  logic [3:0] gpio_dout_in = 4'h0, gpio_oe_in = 4'h0, gpio_din_out;
  logic uart_sel_in = 1'h0, uart_tx_in = 1'h0, uart_rx_out, wake_pin_en_in = 1'h0;
  logic low_frequency_receiver_in = 1'h0, interval_timer_in = 1'h0, resume_in = 1'h0;
  logic enter_idle_in = 1'h0, enter_deep_idle_in = 1'h0, enter_powerdown_in = 1'h0;
  logic handler_ready_out, window_open_out, mode_valid_out, app_start_out;
  logic restart_vector_out, cpu_run_out, power_down_out, host_byte_valid_out;
  logic [7:0] host_byte_out, b;
  smsw_mode_t mode_out;
  int fail_count = 0, n_checks = 0, cyc = 0, app_n = 0, app_t = 0, pd, up, n0;
  logic app_v;
  logic [2:0] ak;
  logic [15:0] codes[4];
  logic [7:0] host_q[$], exp_q[$];

  always #2.5 clk_in = ~clk_in;

  // open-drain wires with pull-ups
  assign scl_in = m_scl & ~(scl_oe_out & ~scl_out);
  assign sda_in = m_sda & ~(sda_oe_out & ~sda_out);

  smsw_top #(.WIN_CYCLES(WIN), .PD_HOLD_CYCLES(PDH), .BOOT_CYCLES(BOOT),
    .INI_CYCLES(INI)) uut (
    .clk_in, .reset_n_in, .scl_in, .scl_out, .scl_oe_out, .sda_in, .sda_out,
    .sda_oe_out, .wake_pin_uart_rx_in, .wake_pin_uart_rx_out, .wake_pin_uart_rx_oe_out,
    .gpio_uart_tx_in, .gpio_uart_tx_out, .gpio_uart_tx_oe_out,
    .gpio_dout_in, .gpio_oe_in, .gpio_din_out, .uart_sel_in, .uart_tx_in,
    .uart_rx_out, .wake_pin_en_in, .low_frequency_receiver_in, .interval_timer_in, .resume_in,
    .enter_idle_in, .enter_deep_idle_in, .enter_powerdown_in, .handler_ready_out,
    .window_open_out, .mode_valid_out, .mode_out, .app_start_out,
    .restart_vector_out, .cpu_run_out, .power_down_out, .host_byte_out,
    .host_byte_valid_out);

  smsw_twi_master bus (.clk_in, .sda_in, .scl_rel_out(m_scl), .sda_rel_out(m_sda));

  // cycle count, application starts and forwarded host bytes
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (app_start_out === 1'h1) begin
      app_n <= app_n + 1;
      app_t <= cyc;
      app_v <= restart_vector_out;
    end
    if (host_byte_valid_out === 1'h1) host_q.push_back(host_byte_out);
  end

  // mode expected from a received code
  function automatic smsw_mode_t exp_mode(input logic [15:0] c);
    case (c)
      `SMSW_CODE_PROGRAM: return SMSW_MODE_PROGRAM;
      `SMSW_CODE_DEBUG: return SMSW_MODE_DEBUG;
      default: return SMSW_MODE_NORMAL;
    endcase
  endfunction

  // comparison helpers
  task automatic miss(input string what);
    fail_count++;
    $display("[ERR] %0t %s", $time, what);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) miss(what);
  endtask
  task automatic chk_mode(input smsw_mode_t got, input smsw_mode_t exp, input string what);
    n_checks++;
    if (got !== exp) miss(what);
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) miss(what);
  endtask
  task automatic chk_le(input int lo, input int hi, input string what);
    n_checks++;
    if (!(lo <= hi)) miss(what);
  endtask

  // power-on reset held 20 cycles
  task automatic do_reset();
    @(negedge clk_in);
    reset_n_in = 1'h0;
    repeat (20) @(negedge clk_in);
    reset_n_in = 1'h1;
    host_q.delete();
    exp_q.delete();
  endtask

  // address byte then up to two code bytes
  task automatic xfer(input logic [7:0] a, input logic [15:0] c, input int n);
    ak = 3'h0;
    bus.start();
    bus.put(a, ak[2]);
    bus.put(c[15:8], ak[1]);
    if (n > 2) bus.put(c[7:0], ak[0]);
    bus.stop();
  endtask

  // one-cycle state request: 0 idle, 1 deep idle, 2 power-down
  task automatic enter(input int k);
    {enter_powerdown_in, enter_deep_idle_in, enter_idle_in} = 3'h1 << k;
    @(negedge clk_in);
    {enter_powerdown_in, enter_deep_idle_in, enter_idle_in} = 3'h0;
  endtask

  // wait for an application start, counting power-down and other cycles
  task automatic wait_app(input int lim);
    int s0;
    s0 = app_n;
    pd = 0;
    up = 0;
    while (app_n == s0 && pd + up < lim) begin
      @(negedge clk_in);
      if (power_down_out === 1'h1) pd++;
      else up++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    #(5 * 60000);
    fail_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    void'($urandom(32'h411f_1ad5));
    do_reset();
    chk_bit(window_open_out, 1'h1, "window open");
    chk_bit(mode_valid_out, 1'h0, "not locked");
    repeat (INI) @(negedge clk_in);
    chk_bit(handler_ready_out, 1'h1, "handler ready");
    // silent window falls back to normal
    wait_app(WIN + 40);
    chk_le(WIN - 40, up, "window short");
    chk_le(up, WIN + 10, "window long");
    chk_mode(mode_out, SMSW_MODE_NORMAL, "default mode");
    chk_bit(app_v, 1'h1, "default vector");
    xfer(8'h6c, `SMSW_CODE_PROGRAM, 3);
    chk_bit(ak[2], 1'h0, "late ack");
    chk_mode(mode_out, SMSW_MODE_NORMAL, "late mode");
    // every code, an unknown one last but one, normal last
    codes = '{`SMSW_CODE_PROGRAM, `SMSW_CODE_DEBUG, {8'h00, 8'($urandom)},
      `SMSW_CODE_NORMAL};
    foreach (codes[i]) begin
      do_reset();
      repeat (5) @(negedge clk_in);
      xfer(8'h6a, codes[i], 3);
      chk_bit(ak[2], 1'h0, "bad address");
      chk_bit(window_open_out, 1'h1, "still open");
      xfer(8'h6c, codes[i], 2);
      chk_bit(ak[2], 1'h1, "short select addressed");
      chk_bit(window_open_out, 1'h1, "short select ignored");
      n0 = app_n;
      xfer(8'h6c, codes[i], 3);
      repeat (2) @(negedge clk_in);
      chk_bit(ak === 3'h7, 1'h1, "acks");
      chk_mode(mode_out, exp_mode(codes[i]), "mode");
      chk_bit(mode_valid_out, 1'h1, "locked");
      chk_bit(window_open_out, 1'h0, "closed");
      chk_bit(app_n != n0, exp_mode(codes[i]) == SMSW_MODE_NORMAL, "app");
      if (app_n != n0) chk_le(cyc - app_t, 30, "app delay");
      b = 8'($urandom);
      if (exp_mode(codes[i]) != SMSW_MODE_NORMAL) exp_q.push_back(b);
      xfer(8'h6c, {b, 8'h00}, 2);
      repeat (8) @(negedge clk_in);
      chk_bit(host_q.size() == exp_q.size(), 1'h1, "host count");
      while (exp_q.size() > 0 && host_q.size() > 0)
        chk_byte(host_q.pop_front(), exp_q.pop_front(), "host byte");
    end
    // idle continues where it stopped
    enter(0);
    chk_bit(cpu_run_out, 1'h0, "idle halt");
    resume_in = 1'h1;
    wait_app(10);
    resume_in = 1'h0;
    chk_le(pd + up, 8, "idle resume");
    chk_bit(app_v, 1'h0, "idle vector");
    // let the synchronised resume fall before the next request
    repeat (4) @(negedge clk_in);
    // deep idle restarts from the vector
    enter(1);
    resume_in = 1'h1;
    wait_app(BOOT + 10);
    resume_in = 1'h0;
    chk_le(pd + up, BOOT + 6, "resume time");
    chk_bit(app_v, 1'h1, "deep vector");
    // power-down woken by each source in turn
    wake_pin_en_in = 1'h1;
    for (int s = 0; s < 3; s++) begin
      enter(2);
      chk_bit(power_down_out, 1'h1, "asleep");
      repeat (5) @(negedge clk_in);
      {wake_pin_uart_rx_in, interval_timer_in, low_frequency_receiver_in} =
        {wake_pin_uart_rx_in ^ (s == 2), s == 1, s == 0};
      wait_app(PDH + BOOT + 20);
      {interval_timer_in, low_frequency_receiver_in} = 2'h0;
      // stale synchronised wake would cut the next power-down short
      repeat (4) @(negedge clk_in);
      chk_le(pd + up, PDH + BOOT + 8, "wake time");
      chk_le(up, BOOT + 4, "run part");
      chk_le(PDH, pd, "held down");
      chk_bit(app_v, 1'h1, "wake vector");
    end
    wake_pin_en_in = 1'h0;
    // pin routing under random drive
    repeat (24) begin
      {uart_sel_in, uart_tx_in, wake_pin_uart_rx_in, gpio_uart_tx_in, gpio_dout_in,
        gpio_oe_in} = 12'($urandom);
      repeat (4) @(negedge clk_in);
      if (uart_sel_in) begin
        chk_bit(gpio_uart_tx_out, uart_tx_in, "tx");
        chk_bit(gpio_uart_tx_oe_out, 1'h1, "tx drive");
        chk_bit(wake_pin_uart_rx_oe_out, 1'h0, "rx input");
        chk_bit(uart_rx_out, wake_pin_uart_rx_in, "rx");
      end else begin
        chk_bit(gpio_uart_tx_out, gpio_dout_in[3], "gpio3");
        chk_bit(gpio_uart_tx_oe_out, gpio_oe_in[3], "gpio3 drive");
        chk_bit(wake_pin_uart_rx_oe_out, gpio_oe_in[2], "gpio2 drive");
      end
      chk_bit(wake_pin_uart_rx_out, gpio_dout_in[2], "gpio2");
      chk_bit(scl_out, gpio_dout_in[0], "gpio0");
      chk_bit(scl_oe_out, gpio_oe_in[0], "gpio0 drive");
      chk_bit(sda_out, gpio_dout_in[1], "gpio1");
      chk_bit(sda_oe_out, gpio_oe_in[1], "gpio1 drive");
      chk_byte({4'h0, gpio_din_out},
        {4'h0, gpio_uart_tx_in, wake_pin_uart_rx_in, sda_in, scl_in}, "levels");
    end
    tally_and_finish();
  end
endmodule // smsw_top_tb

// >>> smsw_twi_master.sv
/*
  two-wire bus master model that sends mode select and host transfers.
  assumes the bench resolves both wires with pull-ups and feeds sda back.
*/
`timescale 1ns/1ps
module smsw_twi_master #(
  parameter int HALF = 8
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_rel_out,
  output logic sda_rel_out
);
  // both lines released until the first transfer
  initial begin
    scl_rel_out = 1'h1;
    sda_rel_out = 1'h1;
  end

  // one step of the bus clock: high for one step and low for two in each bit, well above the 4-cycle minimum
  task automatic hold();
    repeat (HALF) @(negedge clk_in);
  endtask

  // start: data falls while the clock is high
  task automatic start();
    sda_rel_out = 1'h0;
    hold();
    scl_rel_out = 1'h0;
    hold();
  endtask

  // eight bits msb first, data only changed while clock is low
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_rel_out = (i == 0) ? 1'h1 : b[i-1];
      hold();
      scl_rel_out = 1'h1;
      hold();
      ack = ~sda_in;
      scl_rel_out = 1'h0;
      hold();
    end
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    sda_rel_out = 1'h0;
    hold();
    scl_rel_out = 1'h1;
    hold();
    sda_rel_out = 1'h1;
    hold();
  endtask
endmodule // smsw_twi_master
